// file: shared/lmp_pkg.sv
/*
   Shared constants, types and helpers for the LED matrix PWM dimming block.
   Assumes a single 40 MHz reference clock that stands in for the internal
   PWM oscillator, and a host that drives configuration as plain ports.
*/
package lmp_pkg;

   //**************************************************************
   // Geometry
   //**************************************************************
   localparam int NUM_SINKS = 18;
   localparam int NUM_LINES = 8;
   localparam int NUM_DOTS  = NUM_SINKS * NUM_LINES;

   //**************************************************************
   // Timing
   //**************************************************************
   localparam int CLK_HZ        = 40_000_000;
   localparam int CLK_PERIOD_PS = 25_000;
   // PWM rates in tenths of a hertz so that 62.5 kHz stays exact.
   localparam int PWM_FAST_DHZ  = 1_250_000;
   localparam int PWM_SLOW_DHZ  = 625_000;
   localparam logic [9:0] PERIOD_FAST_CYC = 10'(CLK_HZ * 10 / PWM_FAST_DHZ);
   localparam logic [9:0] PERIOD_SLOW_CYC = 10'(CLK_HZ * 10 / PWM_SLOW_DHZ);
   localparam int PHASE_SHIFT_PS   = 125_000;
   localparam int SINK_DLY_SLOW_PS = 62_500;
   localparam int SINK_DLY_FAST_PS = 31_250;
   // Least times, so each rounds up to whole clocks.
   localparam logic [9:0] PHASE_CYC =
      10'((PHASE_SHIFT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [9:0] SINK_DLY_SLOW_CYC =
      10'((SINK_DLY_SLOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [9:0] SINK_DLY_FAST_CYC =
      10'((SINK_DLY_FAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   //**************************************************************
   // Encodings and thresholds
   //**************************************************************
   typedef enum logic [1:0] {
      LMP_MODE_1    = 2'h0,
      LMP_MODE_2    = 2'h1,
      LMP_MODE_3    = 2'h2,
      LMP_MODE_RSVD = 2'h3
   } lmp_mode_t;

   localparam logic [1:0]  GRP_NONE       = 2'h0;
   localparam logic [1:0]  GRP_ONE        = 2'h1;
   localparam logic [1:0]  GRP_TWO        = 2'h2;
   localparam logic [1:0]  GRP_THREE      = 2'h3;
   localparam logic [7:0]  DUTY_FULL8     = 8'hff;
   localparam logic [7:0]  FAULT_MIN8     = 8'h19;
   localparam logic [15:0] FAULT_MIN16    = 16'h1900;
   localparam logic [2:0]  FAULT_RUN      = 3'h4;
   localparam logic [7:0]  CLEAR_KEY      = 8'h0f;

   // Flat dot number of a sink on a scan line.
   function automatic logic [7:0] lmp_dot_index(input logic [2:0] line,
                                                input logic [4:0] sink);
      return 8'(int'(line) * NUM_SINKS + int'(sink));
   endfunction

endpackage

// file: shared/lmp_scan_if.sv
/*
   Scan status bundle passed from the matrix scanner to the fault filters.
   Assumes both ends run on ref_clk.
*/
`timescale 1ns/100ps
interface lmp_scan_if #(parameter int NUM_SINKS = 18);
   logic                 line_end;   // Last clock of a line's PWM period.
   logic [2:0]           line;       // Scan line now shown.
   logic [NUM_SINKS-1:0] qualify;    // Duty high enough for fault checks.

   modport scan (output line_end, output line, output qualify);
   modport filt (input line_end, input line, input qualify);
endinterface // lmp_scan_if

// file: verilog/lmp_duty_calc.sv
/*
   Combines individual, group and global duty, applies the scale curve and
   turns the result into a count of on clocks within one PWM period.
   Assumes the caller widens 8-bit duties to 16 bits by repeating the byte.
*/
`timescale 1ns/100ps
module lmp_duty_calc (
   input  wire logic [15:0] ind_duty,
   input  wire logic [7:0]  grp_duty,
   input  wire logic [7:0]  glob_duty,
   input  wire logic        exp_scale,
   input  wire logic [9:0]  period_cyc,
   output logic      [9:0]  on_cyc
);
   logic [8:0]  grp_n;
   logic [8:0]  glob_n;
   logic [24:0] prod_a;
   logic [24:0] prod_b;
   logic [15:0] lin;
   logic [31:0] sq;
   logic [16:0] fin;
   logic [26:0] on_prod;

   //**************************************************************
   // Product and scale
   //**************************************************************
   // Mapping 255 to 256 lets shifts replace a divide by 255; the error is
   // under half a step, which the eye cannot see.
   always_comb begin
      grp_n   = {1'b0, grp_duty} + 9'(grp_duty[7]);
      glob_n  = {1'b0, glob_duty} + 9'(glob_duty[7]);
      prod_a  = ind_duty * grp_n;
      prod_b  = prod_a[23:8] * glob_n;
      lin     = prod_b[23:8];
      sq      = lin * lin;
      fin     = exp_scale ? {1'b0, sq[31:16]} : {1'b0, lin};
      // A zero duty gives zero clocks; full duty fills the period, or all but one clock of it with the scale curve.
      on_prod = (fin + 17'h1) * period_cyc;
      on_cyc  = (fin == 17'h0) ? 10'h0 : on_prod[25:16];
   end

endmodule // lmp_duty_calc

// file: verilog/lmp_fault_filter.sv
/*
   Per-dot fault filter: counts consecutive sub-periods in which a sink shows
   the fault level and raises sticky flags. Used once for open and once for
   short faults. Assumes each dot is visited once per sub-period.
*/
`timescale 1ns/100ps
module lmp_fault_filter
   import lmp_pkg::*;
#(
   parameter int NUM_SINKS = lmp_pkg::NUM_SINKS,
   parameter int NUM_DOTS  = lmp_pkg::NUM_DOTS
) (
   input  wire logic                  ref_clk,
   input  wire logic                  arst_n,
   lmp_scan_if.filt                   scan,
   input  wire logic [NUM_SINKS-1:0]  hit,
   input  wire logic                  clear_wr,
   input  wire logic [7:0]            clear_data,
   output logic      [NUM_DOTS-1:0]   flags,
   output logic                       any_fault
);
   import lmp_pkg::*;

   typedef struct packed {
      logic [NUM_DOTS-1:0][2:0] run;
      logic [NUM_DOTS-1:0]      flag;
      logic                     any;
   } lmp_filt_state_t;

   lmp_filt_state_t st_ff;
   lmp_filt_state_t nxt_st;

   //**************************************************************
   // Run counting and sticky flags
   //**************************************************************
   // The clear is applied first so that a fault found in the same clock
   // survives it.
   always_comb begin
      logic [7:0] d;
      d      = 8'h0;
      nxt_st = st_ff;
      if (clear_wr && clear_data == CLEAR_KEY) begin
         nxt_st.flag = '0;
         nxt_st.any  = 1'b0;
      end
      if (scan.line_end) begin
         for (int s = 0; s < NUM_SINKS; s++) begin
            d = lmp_dot_index(scan.line, 5'(s));
            if (scan.qualify[s] && hit[s]) begin
               if (st_ff.run[d] < FAULT_RUN) begin
                  nxt_st.run[d] = st_ff.run[d] + 3'h1;
               end
               if (st_ff.run[d] + 3'h1 >= FAULT_RUN) begin
                  nxt_st.flag[d] = 1'b1;
                  nxt_st.any     = 1'b1;
               end
            end else begin
               nxt_st.run[d] = 3'h0;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign flags     = st_ff.flag;
   assign any_fault = st_ff.any;

endmodule // lmp_fault_filter

// file: verilog/lmp_pwm_top.sv
/*
   LED matrix PWM dimming: duty storage, refresh modes, scan and PWM timing,
   phase stagger, sink delay, and open and short fault handling.
   Assumes all inputs are synchronous to ref_clk, which stands for the
   internal PWM oscillator, and that comparator inputs report sink levels.
*/
`timescale 1ns/100ps
module lmp_pwm_top
   import lmp_pkg::*;
#(
   parameter int NUM_SINKS = lmp_pkg::NUM_SINKS,
   parameter int NUM_LINES = lmp_pkg::NUM_LINES,
   parameter int NUM_DOTS  = lmp_pkg::NUM_DOTS
) (
   input  wire logic                  ref_clk,
   input  wire logic                  arst_n,
   // Configuration.
   input  wire lmp_pkg::lmp_mode_t    refresh_mode,
   input  wire logic                  pwm_freq_sel,
   input  wire logic                  phase_shift_en,
   input  wire logic                  sink_delay_en,
   input  wire logic                  exp_scale_en,
   input  wire logic [3:0]            active_lines,
   input  wire logic [7:0]            group_duty_1,
   input  wire logic [7:0]            group_duty_2,
   input  wire logic [7:0]            group_duty_3,
   input  wire logic [7:0]            global_duty,
   input  wire logic                  open_sink_cutoff,
   input  wire logic                  short_deghost_cutoff,
   // Dot duty writes.
   input  wire logic                  duty_wr_en,
   input  wire logic                  duty_wr_wide,
   input  wire logic [7:0]            duty_wr_addr,
   input  wire logic [15:0]           duty_wr_data,
   // Group select and on/off writes.
   input  wire logic                  group_wr_en,
   input  wire logic [7:0]            group_wr_addr,
   input  wire logic [1:0]            dot_group_select,
   input  wire logic                  onoff_wr_en,
   input  wire logic [7:0]            onoff_wr_addr,
   input  wire logic                  onoff_wr_val,
   // Frame sync.
   input  wire logic                  frame_sync,
   // Fault comparators and clears.
   input  wire logic [NUM_SINKS-1:0]  sink_below_open,
   input  wire logic [NUM_SINKS-1:0]  sink_above_short,
   input  wire logic                  open_flag_clear,
   input  wire logic                  short_flag_clear,
   input  wire logic [7:0]            clear_data,
   // Outputs.
   output logic      [NUM_SINKS-1:0]  current_sink_pin,
   output logic      [NUM_LINES-1:0]  scan_line_on,
   output logic      [NUM_LINES-1:0]  upside_deghost_en,
   output logic      [NUM_DOTS-1:0]   open_detect,
   output logic      [NUM_DOTS-1:0]   short_detect,
   output logic                       any_open_fault,
   output logic                       any_short_fault
);
   import lmp_pkg::*;

   //**************************************************************
   // State
   //**************************************************************
   typedef struct packed {
      logic [9:0]                 pwm_cnt;
      logic [2:0]                 line;
      logic                       sync_prev;
      logic [NUM_DOTS-1:0]        dot_on;
      logic [NUM_DOTS-1:0][1:0]   group;
      logic [NUM_SINKS-1:0]       low_seen;
      logic [NUM_SINKS-1:0]       high_seen;
      logic [NUM_SINKS-1:0]       sink_pin;
      logic [NUM_LINES-1:0]       line_pin;
      logic [NUM_LINES-1:0]       deghost;
   } lmp_top_state_t;

   lmp_top_state_t st_ff;
   lmp_top_state_t nxt_st;

   // Duty storage: write buffers and the frame shown in synced modes.
   logic [7:0]  duty8_buf   [NUM_DOTS];
   logic [15:0] duty16_buf  [NUM_DOTS];
   logic [7:0]  duty8_show  [NUM_DOTS];
   logic [15:0] duty16_show [NUM_DOTS];

   logic [15:0] ind_duty [NUM_SINKS];
   logic [7:0]  grp_duty [NUM_SINKS];
   logic [9:0]  on_cyc   [NUM_SINKS];
   logic [9:0]  period_cyc;
   logic [9:0]  sink_dly;
   logic [2:0]  last_line;
   logic        line_end;
   logic        frame_edge;
   logic        synced_mode;
   logic [NUM_SINKS-1:0] qualify;

   lmp_scan_if #(.NUM_SINKS(NUM_SINKS)) scan_bus ();

   //**************************************************************
   // Rate and sequencing decode
   //**************************************************************
   // A zero line count would stall the scan, so it is treated as one.
   always_comb begin
      period_cyc  = pwm_freq_sel ? PERIOD_SLOW_CYC : PERIOD_FAST_CYC;
      sink_dly    = pwm_freq_sel ? SINK_DLY_SLOW_CYC : SINK_DLY_FAST_CYC;
      last_line   = (active_lines == 4'h0) ? 3'h0 : 3'(active_lines - 4'h1);
      line_end    = (st_ff.pwm_cnt == period_cyc - 10'h1);
      frame_edge  = frame_sync && !st_ff.sync_prev;
      synced_mode = (refresh_mode == LMP_MODE_2) || (refresh_mode == LMP_MODE_3);
   end

   //**************************************************************
   // Duty storage and frame transfer
   //**************************************************************
   // The frame copy reads the buffers before this clock's write lands, so a
   // write in the sync clock waits for the following frame.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NUM_DOTS; i++) begin
            duty8_buf[i]   <= 8'h0;
            duty16_buf[i]  <= 16'h0;
            duty8_show[i]  <= 8'h0;
            duty16_show[i] <= 16'h0;
         end
      end else begin
         if (synced_mode && frame_edge) begin
            for (int i = 0; i < NUM_DOTS; i++) begin
               duty8_show[i]  <= duty8_buf[i];
               duty16_show[i] <= duty16_buf[i];
            end
         end
         if (duty_wr_en && int'(duty_wr_addr) < NUM_DOTS) begin
            if (duty_wr_wide) begin
               duty16_buf[duty_wr_addr] <= duty_wr_data;
            end else begin
               duty8_buf[duty_wr_addr] <= duty_wr_data[7:0];
            end
         end
      end
   end

   //**************************************************************
   // Per-sink duty selection for the current line
   //**************************************************************
   // Mode 1 reads the write buffer directly, so a single dot write shows at
   // once; the reserved mode code behaves as mode 1.
   always_comb begin
      logic [7:0] d;
      d = 8'h0;
      for (int s = 0; s < NUM_SINKS; s++) begin
         d = lmp_dot_index(st_ff.line, 5'(s));
         unique case (refresh_mode)
            LMP_MODE_2: ind_duty[s] = {duty8_show[d], duty8_show[d]};
            LMP_MODE_3: ind_duty[s] = duty16_show[d];
            default:    ind_duty[s] = {duty8_buf[d], duty8_buf[d]};
         endcase
         unique case (st_ff.group[d])
            GRP_ONE:   grp_duty[s] = group_duty_1;
            GRP_TWO:   grp_duty[s] = group_duty_2;
            GRP_THREE: grp_duty[s] = group_duty_3;
            default:   grp_duty[s] = DUTY_FULL8;
         endcase
         if (refresh_mode == LMP_MODE_3) begin
            qualify[s] = (ind_duty[s] >= FAULT_MIN16);
         end else begin
            qualify[s] = (ind_duty[s][7:0] >= FAULT_MIN8);
         end
      end
   end

   for (genvar s = 0; s < NUM_SINKS; s++) begin : g_duty
      lmp_duty_calc u_calc (
         .ind_duty   (ind_duty[s]),
         .grp_duty   (grp_duty[s]),
         .glob_duty  (global_duty),
         .exp_scale  (exp_scale_en),
         .period_cyc (period_cyc),
         .on_cyc     (on_cyc[s])
      );
   end

   //**************************************************************
   // Scan, PWM and fault observation
   //**************************************************************
   // One PWM period per line; a full pass over the active lines is one
   // sub-period, the unit in which fault runs are counted.
   always_comb begin
      logic [7:0] d;
      logic [9:0] start;
      logic [9:0] rel;
      logic [2:0] nline;
      d      = 8'h0;
      start  = 10'h0;
      rel    = 10'h0;
      nline  = 3'h0;
      nxt_st = st_ff;
      nxt_st.sync_prev = frame_sync;

      if (line_end) begin
         nxt_st.pwm_cnt = 10'h0;
         nline = (st_ff.line >= last_line) ? 3'h0 : st_ff.line + 3'h1;
         nxt_st.line      = nline;
         nxt_st.low_seen  = '0;
         nxt_st.high_seen = '0;
      end else begin
         nline = st_ff.line;
         nxt_st.pwm_cnt = st_ff.pwm_cnt + 10'h1;
      end

      if (group_wr_en && int'(group_wr_addr) < NUM_DOTS) begin
         nxt_st.group[group_wr_addr] = dot_group_select;
      end
      if (onoff_wr_en && int'(onoff_wr_addr) < NUM_DOTS) begin
         nxt_st.dot_on[onoff_wr_addr] = onoff_wr_val;
      end

      // Comparator levels count only while the sink is really driving.
      if (!line_end) begin
         nxt_st.low_seen  = st_ff.low_seen | (st_ff.sink_pin & sink_below_open);
         nxt_st.high_seen = st_ff.high_seen | (st_ff.sink_pin & sink_above_short);
      end

      for (int s = 0; s < NUM_SINKS; s++) begin
         d     = lmp_dot_index(st_ff.line, 5'(s));
         start = (phase_shift_en ? 10'(s % 3) * PHASE_CYC : 10'h0)
               + (sink_delay_en ? sink_dly : 10'h0);
         rel   = st_ff.pwm_cnt - start;
         nxt_st.sink_pin[s] = !line_end
                            && (st_ff.pwm_cnt >= start)
                            && (rel < on_cyc[s])
                            && st_ff.dot_on[d]
                            && !(open_sink_cutoff && open_detect[d]);
      end

      for (int l = 0; l < NUM_LINES; l++) begin
         nxt_st.line_pin[l] = (3'(l) == nline) && (l <= int'(last_line));
         nxt_st.deghost[l]  = 1'b1;
         if (short_deghost_cutoff) begin
            for (int s = 0; s < NUM_SINKS; s++) begin
               if (short_detect[lmp_dot_index(3'(l), 5'(s))]) begin
                  nxt_st.deghost[l] = 1'b0;
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   //**************************************************************
   // Fault filters
   //**************************************************************
   assign scan_bus.line_end = line_end;
   assign scan_bus.line     = st_ff.line;
   assign scan_bus.qualify  = qualify;

   lmp_fault_filter #(.NUM_SINKS(NUM_SINKS), .NUM_DOTS(NUM_DOTS)) u_open (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .scan       (scan_bus.filt),
      .hit        (st_ff.low_seen),
      .clear_wr   (open_flag_clear),
      .clear_data (clear_data),
      .flags      (open_detect),
      .any_fault  (any_open_fault)
   );

   lmp_fault_filter #(.NUM_SINKS(NUM_SINKS), .NUM_DOTS(NUM_DOTS)) u_short (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .scan       (scan_bus.filt),
      .hit        (st_ff.high_seen),
      .clear_wr   (short_flag_clear),
      .clear_data (clear_data),
      .flags      (short_detect),
      .any_fault  (any_short_fault)
   );

   //**************************************************************
   // Pins
   //**************************************************************
   assign current_sink_pin  = st_ff.sink_pin;
   assign scan_line_on      = st_ff.line_pin;
   assign upside_deghost_en = st_ff.deghost;

endmodule // lmp_pwm_top

// file: verification/lmp_pwm_top_sva.sv
/* Checker for the PWM dimming top: fault flags, sink timing, deghosting.
   Assumes it is bound to lmp_pwm_top and sees only that module's ports. */
`timescale 1ns/100ps
module lmp_pwm_chk #(parameter int NUM_SINKS = 18, NUM_LINES = 8, NUM_DOTS = 144) (
   input wire logic                 ref_clk,
   input wire logic                 arst_n,
   input wire logic                 phase_shift_en,
   input wire logic                 sink_delay_en,
   input wire logic                 open_sink_cutoff,
   input wire logic                 short_deghost_cutoff,
   input wire logic                 open_flag_clear,
   input wire logic                 short_flag_clear,
   input wire logic [7:0]           clear_data,
   input wire logic [NUM_SINKS-1:0] current_sink_pin,
   input wire logic [NUM_LINES-1:0] scan_line_on,
   input wire logic [NUM_LINES-1:0] upside_deghost_en,
   input wire logic [NUM_DOTS-1:0]  open_detect,
   input wire logic [NUM_DOTS-1:0]  short_detect,
   input wire logic                 any_open_fault,
   input wire logic                 any_short_fault
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Flags may only fall on a keyed clear, so a flag that drops on its own shows up.
   open_sticky_a: assert property (
      !(open_flag_clear && clear_data == 8'h0f) |=> ($past(open_detect) & ~open_detect) == '0)
      else $error("open flag fell without clear");
   short_sticky_a: assert property (
      !(short_flag_clear && clear_data == 8'h0f) |=> ($past(short_detect) & ~short_detect) == '0)
      else $error("short flag fell without clear");
   open_any_a: assert property (open_detect != '0 |-> any_open_fault)
      else $error("global open flag missing");
   short_any_a: assert property (short_detect != '0 |-> any_short_fault)
      else $error("global short flag missing");
   sink_dly_a: assert property (
      sink_delay_en && $changed(scan_line_on) && $past(scan_line_on) != '0
      |=> current_sink_pin == '0) else $error("sink on without delay");
   phase_a: assert property (
      phase_shift_en && $changed(scan_line_on) && $past(scan_line_on) != '0
      |=> !current_sink_pin[1] [*5]) else $error("second phase started early");
   deghost_cut_a: assert property (
      short_deghost_cutoff && short_detect[NUM_SINKS-1:0] != '0 |=> !upside_deghost_en[0])
      else $error("deghost kept on a shorted line");
   // The sink pin is registered, so the cutoff must already have stood one clock.
   open_cut_a: assert property (
      $past(open_sink_cutoff) && open_sink_cutoff && open_detect[0] && scan_line_on[0]
      |-> !current_sink_pin[0])
      else $error("open sink not cut off");
   cover property (any_open_fault);
   cover property (any_short_fault);
   cover property ($fell(upside_deghost_en[0]));
endmodule // lmp_pwm_chk

bind lmp_pwm_top lmp_pwm_chk #(.NUM_SINKS(NUM_SINKS), .NUM_LINES(NUM_LINES),
   .NUM_DOTS(NUM_DOTS)) u_chk (.*);

// file: verification/lmp_led_model.sv
/* LED matrix model: sink comparators react to a switched-on sink.
   Assumes the masks mark which dots on the lit line are open or shorted. */
`timescale 1ns/100ps
module lmp_led_model (
   input wire logic [17:0] current_sink_pin,
   input wire logic [17:0] open_mask,
   input wire logic [17:0] short_mask,
   output logic     [17:0] sink_below_open,
   output logic     [17:0] sink_above_short
);
   // A faulty dot only shows its level while current flows; a dark sink looks healthy.
   assign sink_below_open  = current_sink_pin & open_mask;
   assign sink_above_short = current_sink_pin & short_mask;
endmodule // lmp_led_model

// file: verification/lmp_pwm_top_tb_top.sv
/* Self-checking bench for the PWM dimming top with an LED matrix model.
   Assumes two scan lines, so one sub-period is two line periods. */
`timescale 1ns/100ps
module lmp_pwm_top_tb_top;
   import lmp_pkg::*;
   logic ref_clk, arst_n, pwm_freq_sel, phase_shift_en, sink_delay_en, exp_scale_en, seen;
   lmp_mode_t refresh_mode;
   logic [3:0] active_lines;
   logic [7:0] group_duty_1, group_duty_2, group_duty_3, global_duty, clear_data;
   logic open_sink_cutoff, short_deghost_cutoff, open_flag_clear, short_flag_clear, frame_sync;
   logic duty_wr_en, duty_wr_wide, group_wr_en, onoff_wr_en, onoff_wr_val;
   logic [7:0] duty_wr_addr, group_wr_addr, onoff_wr_addr, scan_line_on, upside_deghost_en;
   logic [15:0] duty_wr_data;
   logic [1:0] dot_group_select;
   logic [17:0] sink_below_open, sink_above_short, current_sink_pin, open_mask, short_mask;
   logic [143:0] open_detect, short_detect;
   logic any_open_fault, any_short_fault;
   logic [4:0] exp_q[$];
   logic [4:0] e;
   logic [31:0] rs = 32'h630b;
   int error_cnt = 0;
   int n_compared = 0;
   event ev;
   lmp_pwm_top u_dut (.*);
   lmp_led_model u_led (.current_sink_pin(current_sink_pin), .open_mask(open_mask),
      .short_mask(short_mask), .sink_below_open(sink_below_open),
      .sink_above_short(sink_above_short));
   // Free-running 40 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One write of kind k: 0 narrow duty, 1 wide duty, 2 group select, 3 on/off.
   task automatic wr(input int k, input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      {duty_wr_en, duty_wr_wide, group_wr_en, onoff_wr_en} <= {k < 2, k == 1, k == 2, k == 3};
      {duty_wr_addr, group_wr_addr, onoff_wr_addr} <= {a, a, a};
      {duty_wr_data, dot_group_select, onoff_wr_val} <= {d, d[1:0], d[0]};
      @(posedge ref_clk);
      {duty_wr_en, group_wr_en, onoff_wr_en} <= 3'h0;
   endtask
   task automatic sync();
      @(posedge ref_clk) frame_sync <= 1'b1;
      @(posedge ref_clk) frame_sync <= 1'b0;
   endtask
   task automatic clr(input logic o, input logic [7:0] d);
      @(posedge ref_clk) {open_flag_clear, short_flag_clear, clear_data} <= {o, !o, d};
      @(posedge ref_clk) {open_flag_clear, short_flag_clear} <= 2'h0;
   endtask
   // Watch longer than a slow sub-period so dot 0 is visited at least once.
   task automatic chk(input logic [4:0] x);
      // Let the last input change reach the registered sink pins before watching.
      repeat (2) @(posedge ref_clk);
      seen = 1'b0;
      repeat (1400) @(posedge ref_clk) seen |= current_sink_pin[0];
      exp_q.push_back(x);
      #1 -> ev;
   endtask
   // Compare outputs against the oldest note.
   always @(ev) begin
      e = exp_q.pop_front();
      n_compared++;
      if ({any_open_fault, open_detect[0], any_short_fault, short_detect[0], seen} !== e) begin
         $display("[ERR] flags_and_lit exp %h got %h", e,
            {any_open_fault, open_detect[0], any_short_fault, short_detect[0], seen});
         error_cnt++;
      end
   end
   initial begin
      #2_000_000 error_cnt++;
      tally_and_finish();
   end
   // Main sequence: refresh modes, group gating, open and short faults.
   initial begin
      {pwm_freq_sel, phase_shift_en, sink_delay_en, exp_scale_en, active_lines, global_duty,
       group_duty_1, group_duty_2, group_duty_3, clear_data, open_sink_cutoff, frame_sync,
       short_deghost_cutoff, open_flag_clear, short_flag_clear, duty_wr_en, duty_wr_wide,
       group_wr_en, onoff_wr_en, onoff_wr_val, duty_wr_addr, group_wr_addr, onoff_wr_addr,
       duty_wr_data, dot_group_select, open_mask, short_mask} = '0;
      refresh_mode = LMP_MODE_1;
      arst_n = 1'b0;
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk) {active_lines, global_duty, group_duty_1} <= {4'h2, 8'hff, 8'hff};
      {phase_shift_en, sink_delay_en} <= 2'h3;
      repeat (6) begin
         rs = xs(rs);
         group_duty_2 <= rs[23:16];
         wr(0, 8'(18 + rs % 126), rs[15:0]);
      end
      wr(0, 8'h00, 16'h00ff);
      wr(2, 8'h00, 16'(GRP_ONE));
      chk(5'h00);
      wr(3, 8'h00, 16'h0001);
      chk(5'h01);
      @(posedge ref_clk) group_duty_1 <= 8'h00;
      chk(5'h00);
      @(posedge ref_clk) {group_duty_1, open_mask, open_sink_cutoff} <= {8'hff, 18'h1, 1'b1};
      chk(5'h01);
      repeat (2600) @(posedge ref_clk);
      chk(5'h18);
      @(posedge ref_clk) open_mask <= '0;
      clr(1'b1, 8'h0e);
      chk(5'h18);
      clr(1'b1, CLEAR_KEY);
      chk(5'h01);
      @(posedge ref_clk) {short_mask, short_deghost_cutoff, open_sink_cutoff} <= {18'h1, 2'h2};
      repeat (2600) @(posedge ref_clk);
      chk(5'h07);
      @(posedge ref_clk) short_mask <= '0;
      clr(1'b0, CLEAR_KEY);
      chk(5'h01);
      @(posedge ref_clk) refresh_mode <= LMP_MODE_2;
      sync();
      wr(0, 8'h00, 16'h0000);
      chk(5'h01);
      sync();
      chk(5'h00);
      wr(0, 8'h00, 16'h00ff);
      @(posedge ref_clk) {refresh_mode, pwm_freq_sel, exp_scale_en} <= {LMP_MODE_3, 2'h3};
      sync();
      chk(5'h00);
      wr(1, 8'h00, 16'hffff);
      sync();
      chk(5'h01);
      @(posedge ref_clk) group_duty_2 <= 8'h00;
      wr(2, 8'h00, 16'(GRP_TWO));
      chk(5'h00);
      wr(2, 8'h00, 16'(GRP_NONE));
      @(posedge ref_clk) refresh_mode <= LMP_MODE_RSVD;
      chk(5'h01);
      // Give the compare process the time step of the last note before the verdict.
      @(posedge ref_clk);
      tally_and_finish();
   end
endmodule // lmp_pwm_top_tb_top
